// >>> verilog/rgcl_cfg.svh
// Constants of the receive gain control loop.
`ifndef RGCL_CFG_SVH
`define RGCL_CFG_SVH

`define RGCL_STEP_DB        6
`define RGCL_MAX_DB         48
`define RGCL_ATTEN_W        6
`define RGCL_STEP_MAX       4'h8
`define RGCL_THR_W          4
`define RGCL_EXP_W          4
`define RGCL_WIN_BASE       12
`define RGCL_WIN_CNT_W      18
`define RGCL_HI_THR_RST     4'hC
`define RGCL_LO_THR_RST     4'h4
`define RGCL_EXP_RST        4'h0

`endif

// >>> verilog/rgcl_pkg.sv
// Types of the receive gain control loop.
`default_nettype none
package rgcl_pkg;
  typedef enum logic [1:0] {rgcl_idle, rgcl_measure, rgcl_decide} rgcl_state_t;
  typedef logic [3:0] rgcl_step_t;
endpackage : rgcl_pkg
`default_nettype wire

// >>> verilog/rgcl_peak_hold.sv
// Peak hold over one measurement window.
`default_nettype none
`include "rgcl_cfg.svh"
module rgcl_peak_hold
  import rgcl_pkg::*;
(
  // Clock and reset.
  input  wire logic                    core_clk,
  input  wire logic                    sys_rst,
  // Control.
  input  wire logic                    clear,
  input  wire logic                    sample_en,
  // Sample in, peak out.
  input  wire logic [`RGCL_THR_W-1:0]  sample,
  output logic      [`RGCL_THR_W-1:0]  peak
);

  logic [`RGCL_THR_W-1:0] next_peak;

  always_comb
  begin
    next_peak = peak;
    if (clear)
    begin
      next_peak = sample_en ? sample : '0;
    end
    else if (sample_en && (sample > peak))
    begin
      next_peak = sample;
    end
  end

  always_ff @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      peak <= '0;
    end
    else
    begin
      peak <= next_peak;
    end
  end

endmodule : rgcl_peak_hold
`default_nettype wire

// >>> verilog/rgcl_loop.sv
// Receive gain control loop: windowed peak compare and attenuation stepping.
//
// Behaviour
// - Attenuation moves in 6 dB steps, max 48.
// - Peak above high threshold: add one step.
// - Peak below low threshold and not above high threshold: remove one step.
// - High threshold programmable 0 to 15.
// - Low threshold programmable 0 to 15.
// - Window is 12 clocks times two^exponent.
// - Loop runs only while enable is set.
`default_nettype none
`include "rgcl_cfg.svh"
module rgcl_loop
  import rgcl_pkg::*;
(
  // Clock and reset.
  input  wire logic                      core_clk,
  input  wire logic                      sys_rst,
  // Configuration.
  input  wire logic                      gain_loop_enable,
  input  wire logic [`RGCL_THR_W-1:0]    high_threshold,
  input  wire logic [`RGCL_THR_W-1:0]    low_threshold,
  input  wire logic [`RGCL_EXP_W-1:0]    peak_window_exponent,
  // Receive peak detector.
  input  wire logic                      sample_valid,
  input  wire logic [`RGCL_THR_W-1:0]    sample_level,
  // Attenuator and status.
  output logic      [`RGCL_ATTEN_W-1:0]  atten_db,
  output logic      [3:0]                atten_step,
  output logic                           window_done,
  output logic      [`RGCL_THR_W-1:0]    last_peak,
  output logic                           loop_active
);

  //////////////////////////////////////////////////////////////////////////////
  // Window length.

  // Longest window is 12 * 2^15 cycles, which fits in 19 bits.
  function automatic logic [`RGCL_WIN_CNT_W:0] win_len(input logic [`RGCL_EXP_W-1:0] e);
    logic [`RGCL_WIN_CNT_W:0] base;
    base    = (`RGCL_WIN_CNT_W+1)'(`RGCL_WIN_BASE);
    win_len = base << e;
  endfunction : win_len

  function automatic logic [`RGCL_ATTEN_W-1:0] to_db(input rgcl_step_t s);
    to_db = `RGCL_ATTEN_W'(s * `RGCL_STEP_DB);
  endfunction : to_db

  //////////////////////////////////////////////////////////////////////////////
  // Enable is synchronised; same-clock detector samples are delayed to stay aligned.

  logic                   en_s1, en_s2;
  logic                   val_s1, val_s2;
  logic [`RGCL_THR_W-1:0] lvl_s1, lvl_s2;

  always_ff @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      en_s1  <= 1'b0;
      en_s2  <= 1'b0;
      val_s1 <= 1'b0;
      val_s2 <= 1'b0;
      lvl_s1 <= '0;
      lvl_s2 <= '0;
    end
    else
    begin
      en_s1  <= gain_loop_enable;
      en_s2  <= en_s1;
      val_s1 <= sample_valid;
      val_s2 <= val_s1;
      lvl_s1 <= sample_level;
      lvl_s2 <= lvl_s1;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Peak store.

  logic                   clear_peak;
  logic [`RGCL_THR_W-1:0] peak;

  rgcl_peak_hold u_peak (
    .core_clk  (core_clk),
    .sys_rst   (sys_rst),
    .clear     (clear_peak),
    .sample_en (val_s2),
    .sample    (lvl_s2),
    .peak      (peak)
  );

  //////////////////////////////////////////////////////////////////////////////
  // Control.

  rgcl_state_t              state, next_state;
  logic [`RGCL_WIN_CNT_W:0] cnt, next_cnt;
  rgcl_step_t               step, next_step;
  logic                     next_done;
  logic [`RGCL_THR_W-1:0]   next_last;

  always_comb
  begin
    next_state = state;
    next_cnt   = cnt;
    next_step  = step;
    next_done  = 1'b0;
    next_last  = last_peak;
    clear_peak = 1'b0;
    if (!en_s2)
    begin
      // Dropping enable abandons any window in flight and releases the attenuator.
      next_state = rgcl_idle;
      next_step  = '0;
      next_cnt   = '0;
      clear_peak = 1'b1;
    end
    else
    begin
      case (state)
        rgcl_idle:
        begin
          next_state = rgcl_measure;
          next_cnt   = '0;
          clear_peak = 1'b1;
        end
        rgcl_measure:
        begin
          next_cnt = cnt + 1'b1;
          // The exponent is read live; change it only while disabled for clean windows.
          // The decide cycle closes the window, so measuring stops one cycle short of W.
          if (next_cnt >= win_len(peak_window_exponent) - 1'b1)
          begin
            next_state = rgcl_decide;
          end
        end
        rgcl_decide:
        begin
          // High wins if the thresholds are crossed, so overload never goes unanswered.
          // At full attenuation an overload holds instead of reaching the low test.
          if (peak > high_threshold)
          begin
            if (step < `RGCL_STEP_MAX)
            begin
              next_step = step + 1'b1;
            end
          end
          else if (peak < low_threshold)
          begin
            if (step != '0)
            begin
              next_step = step - 1'b1;
            end
          end
          next_done  = 1'b1;
          next_last  = peak;
          next_cnt   = '0;
          clear_peak = 1'b1;
          next_state = rgcl_measure;
        end
        default:
        begin
          next_state = rgcl_idle;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      state <= rgcl_idle;
      cnt   <= '0;
      step  <= '0;
    end
    else
    begin
      state <= next_state;
      cnt   <= next_cnt;
      step  <= next_step;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Outputs.

  // Every output is registered so the attenuator never sees a decode glitch.
  logic [`RGCL_ATTEN_W-1:0] next_db;
  rgcl_step_t               next_atten_step;
  logic                     next_active;

  always_comb
  begin
    next_atten_step = next_step;
    next_db         = to_db(next_step);
    next_active     = en_s2;
  end

  always_ff @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      window_done <= 1'b0;
      last_peak   <= '0;
      atten_step  <= '0;
      atten_db    <= '0;
      loop_active <= 1'b0;
    end
    else
    begin
      window_done <= next_done;
      last_peak   <= next_last;
      atten_step  <= next_atten_step;
      atten_db    <= next_db;
      loop_active <= next_active;
    end
  end

endmodule : rgcl_loop
`default_nettype wire

// >>> sim/rgcl_monitor.sv
// Checker of the gain loop outputs.
`default_nettype none
module rgcl_monitor (
  input wire logic       core_clk,
  input wire logic       sys_rst,
  input wire logic [3:0] high_threshold,
  input wire logic [3:0] low_threshold,
  input wire logic [3:0] peak_window_exponent,
  input wire logic [5:0] atten_db,
  input wire logic [3:0] atten_step,
  input wire logic       window_done,
  input wire logic [3:0] last_peak,
  input wire logic       loop_active
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  // The high compare wins, so a low step needs the high compare false.
  wire logic up = last_peak > high_threshold;
  wire logic dn = !up && last_peak < low_threshold;
  a_db_step: assert property (atten_db == atten_step * 6'h06) else $error("bad db");
  a_step_max: assert property (atten_step <= 4'h8) else $error("step over 8");
  a_step_up: assert property (window_done && up && $past(atten_step) < 4'h8
    |-> atten_step == $past(atten_step) + 4'h1) else $error("no step up");
  a_step_down: assert property (window_done && dn && $past(atten_step) > 4'h0
    |-> atten_step == $past(atten_step) - 4'h1) else $error("no step down");
  a_step_hold: assert property (window_done && !up && !dn |-> $stable(atten_step))
    else $error("step moved");
  a_off_zero: assert property (!loop_active && !$past(loop_active)
    |-> atten_step == 4'h0 && !window_done) else $error("active while off");
  a_win_gap: assert property (window_done |=> !window_done [*8]) else $error("done twice");
  a_win_len: assert property (window_done && peak_window_exponent == 4'h1
    |-> ##24 (window_done || !loop_active)) else $error("window not 24");
  a_win_short: assert property (window_done && peak_window_exponent == 4'h0
    |-> ##12 (window_done || !loop_active)) else $error("window not 12");
  a_top_hold: assert property (window_done && up && $past(atten_step) == 4'h8
    |-> atten_step == 4'h8) else $error("overload left full step");
  c_top: cover property (window_done && up && atten_step == 4'h8);
  c_floor: cover property (window_done && dn && atten_step == 4'h0);
  c_hold: cover property (window_done && !up && !dn);
endmodule : rgcl_monitor
bind rgcl_loop rgcl_monitor u_rgcl_monitor (
  .core_clk             (core_clk),
  .sys_rst              (sys_rst),
  .high_threshold       (high_threshold),
  .low_threshold        (low_threshold),
  .peak_window_exponent (peak_window_exponent),
  .atten_db             (atten_db),
  .atten_step           (atten_step),
  .window_done          (window_done),
  .last_peak            (last_peak),
  .loop_active          (loop_active)
);
`default_nettype wire

// >>> sim/rgcl_rx_model.sv
// Peak detector model: valid drops one cycle in four and shows a wrong level.
`default_nettype none
module rgcl_rx_model (
  input  wire logic       core_clk,
  input  wire logic [3:0] level,
  output var  logic       sample_valid = 1'b0,
  output var  logic [3:0] sample_level = 4'h0
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [1:0] tick = 2'h0;
  always @(posedge core_clk)
  begin
    tick <= tick + 2'h1;
    sample_valid <= tick != 2'h3;
    sample_level <= (tick == 2'h3) ? ~level : level;
  end
endmodule : rgcl_rx_model
`default_nettype wire

// >>> sim/rgcl_loop_tb.sv
// Self-checking bench of the gain control loop.
`default_nettype none
`define CHK(n, e, s) begin check_count++; if ((s) !== (e)) begin errors++; \
  $display("[ERR] %s exp %0h got %0h", n, e, s); end end
module rgcl_loop_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic       core_clk = 1'b0, sys_rst = 1'b1, gain_loop_enable = 1'b0;
  logic [3:0] high_threshold = 4'h0, low_threshold = 4'h0, peak_window_exponent = 4'h0;
  logic [3:0] level = 4'h0, exp_step, sample_level, atten_step, last_peak;
  logic [5:0] atten_db;
  logic       sample_valid, window_done, loop_active, gap_known;
  int         errors = 0, check_count = 0, seed = 70835;
  always #20 core_clk = ~core_clk;
  rgcl_loop u_rgcl_loop (
    .core_clk             (core_clk),
    .sys_rst              (sys_rst),
    .gain_loop_enable     (gain_loop_enable),
    .high_threshold       (high_threshold),
    .low_threshold        (low_threshold),
    .peak_window_exponent (peak_window_exponent),
    .sample_valid         (sample_valid),
    .sample_level         (sample_level),
    .atten_db             (atten_db),
    .atten_step           (atten_step),
    .window_done          (window_done),
    .last_peak            (last_peak),
    .loop_active          (loop_active)
  );
  rgcl_rx_model u_rgcl_rx_model (
    .core_clk     (core_clk),
    .level        (level),
    .sample_valid (sample_valid),
    .sample_level (sample_level)
  );
  // One decision per window: overload wins, and both ends saturate.
  function automatic logic [3:0] step_after(input logic [3:0] s, input logic [3:0] pk,
                                            input logic [3:0] hi, input logic [3:0] lo);
    if (pk > hi)
      step_after = (s < 4'h8) ? s + 4'h1 : s;
    else if (pk < lo)
      step_after = (s > 4'h0) ? s - 4'h1 : s;
    else
      step_after = s;
  endfunction : step_after
  function automatic int win_cycles(input logic [3:0] e);
    win_cycles = 12 << e;
  endfunction : win_cycles
  task automatic finish_test;
    $display("errors %0d checks %0d", errors, check_count);
    if (errors == 0 && check_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : finish_test
  task automatic phase(input logic [3:0] hi, input logic [3:0] lo, input int n);
    int t;
    high_threshold <= hi;
    low_threshold <= lo;
    repeat (n)
    begin
      t = 0;
      @(negedge core_clk);
      while (window_done !== 1'b1 && t < 1000)
      begin
        t++;
        @(negedge core_clk);
      end
      if (t >= 1000)
      begin
        errors++;
        finish_test();
      end
      if (gap_known)
        `CHK("gap", win_cycles(peak_window_exponent), t + 1)
      gap_known = 1'b1;
      exp_step = step_after(exp_step, level, hi, lo);
      `CHK("step", exp_step, atten_step)
      `CHK("db", 6'(exp_step * 6), atten_db)
      `CHK("peak", level, last_peak)
      `CHK("active", 1'b1, loop_active)
      @(posedge core_clk);
    end
  endtask : phase
  // Samples arrive late, so the level only moves while the loop is off.
  task automatic run(input logic [3:0] lvl, input logic [3:0] e);
    gain_loop_enable <= 1'b0;
    repeat (16) @(posedge core_clk);
    @(negedge core_clk);
    `CHK("off step", 4'h0, atten_step)
    `CHK("off db", 6'h00, atten_db)
    `CHK("off active", 1'b0, loop_active)
    @(posedge core_clk);
    level <= lvl;
    peak_window_exponent <= e;
    repeat (30) @(posedge core_clk);
    exp_step = 4'h0;
    gap_known = 1'b0;
    gain_loop_enable <= 1'b1;
  endtask : run
  initial
  begin
    repeat (5) @(posedge core_clk);
    sys_rst <= 1'b0;
    @(negedge core_clk);
    `CHK("reset step", 4'h0, atten_step)
    @(posedge core_clk);
    // Short windows on a steady overload climb the step to full attenuation.
    run(4'h7, 4'h0);
    phase(4'h3, 4'h0, 10);
    // Overload at full attenuation must hold, even under the low threshold.
    phase(4'h3, 4'hA, 2);
    phase(4'h7, 4'h7, 2);
    phase(4'hF, 4'h8, 10);
    repeat (8)
    begin
      run(4'($random(seed)), 4'($random(seed)) & 4'h1);
      repeat (3) phase(4'($random(seed)), 4'($random(seed)), 3);
    end
    finish_test();
  end
endmodule : rgcl_loop_tb
`default_nettype wire
